// ==== rtl/eeprom_regs.svh ====
/*
 * Constants of the serial EEPROM command port: opcodes, status bit
 * positions, reset values and program-cycle timing.
 * Assumes a system clock of 200 MHz.
 */
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

`define OP_SET_WEL   8'h06
`define OP_CLR_WEL   8'h04
`define OP_RD_STAT   8'h05
`define OP_WR_STAT   8'h01
`define OP_RD_ARRAY  8'b0000_?011
`define OP_WR_ARRAY  8'b0000_?010

`define ST_BUSY      0
`define ST_WEL       1
`define ST_BP_LO     2
`define ST_BP_HI     3
`define INSTR_A8     3

`define RST_BP       2'h0
`define RST_WEL      1'b0

`define CLK_KHZ      200000
`define T_WP_MS      15
`define WP_CYCLES    (`T_WP_MS * `CLK_KHZ)
`define WAIT_W       22

`endif

// ==== rtl/eeprom_pkg.sv ====
/*
 * Types of the serial EEPROM command port.
 * Assumes nothing beyond the constants header.
 */
package eeprom_pkg;

	typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DATA, PH_READ, PH_IGNORE} phase_t;

	typedef enum logic [1:0] {PG_IDLE, PG_DRAIN, PG_WAIT} prog_t;

	typedef struct packed {
		logic       cs_n;
		logic       sck;
		logic       si;
		logic       hold_n;
		logic       wp_n;
	} pins_t;

	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] data;
	} wr_entry_t;

	typedef struct packed {
		pins_t      meta;
		pins_t      sync;
		logic       sck_d;
		logic       cs_d;
		logic       held;
		phase_t     phase;
		logic [7:0] cmd;
		logic [2:0] bitcnt;
		logic [7:0] sh_in;
		logic [8:0] addr;
		logic [7:0] out_sh;
		logic       so_q;
		logic       reading;
		logic [1:0] bp;
		logic       wel;
		logic [1:0] bp_new;
		logic       bp_pend;
		prog_t      prog;
		logic [21:0] wait_cnt;
	} core_state_t;

endpackage : eeprom_pkg

// ==== rtl/serial_eeprom_command_port.sv ====
/*
 * Serial slave port, instruction decoder, status register and 512-byte
 * array of a small serial EEPROM, with an 8-entry write staging FIFO.
 * Assumes all pins are asynchronous to sys_clk; they are synchronised
 * here and serial clock edges are found by oversampling.
 */
`timescale 1ns/1ps
`include "eeprom_regs.svh"

module write_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data  = store[rd_ptr[AW-1:0]];
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else if (flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (in_valid && in_ready)
				wr_ptr <= (AW+1)'(wr_ptr + 1'b1);
			if (out_valid && out_ready)
				rd_ptr <= (AW+1)'(rd_ptr + 1'b1);
		end
	end
	always_ff @(posedge sys_clk)
	begin
		if (in_valid && in_ready && !flush)
			store[wr_ptr[AW-1:0]] <= in_data;
	end
endmodule : write_fifo

module serial_eeprom_command_port #(
	parameter int WRITE_CYCLES = `WP_CYCLES,
	parameter int FIFO_DEPTH   = 8
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic si,
	input  wire logic hold_n,
	input  wire logic wp_n,
	output logic      so_out,
	output logic      so_oe
);
	eeprom_pkg::core_state_t s_reg;
	eeprom_pkg::core_state_t s_next;
	eeprom_pkg::wr_entry_t   push_entry;
	eeprom_pkg::wr_entry_t   pop_entry;
	logic                    push;
	logic                    push_ready;
	logic                    pop_valid;
	logic                    pop;
	logic                    flush;
	logic [7:0]              mem [0:511];
	logic       sel;
	logic       fall;
	logic       rise;
	logic       cs_rise;
	logic       busy;
	logic [7:0] in_byte;
	logic [7:0] status;
	function automatic logic is_protected(input logic [8:0] a, input logic [1:0] lvl);
		case (lvl)
			2'h1: is_protected = &a[8:7];
			2'h2: is_protected = a[8];
			2'h3: is_protected = 1'b1;
			default: is_protected = 1'b0;
		endcase
	endfunction : is_protected
	assign sel     = !s_reg.sync.cs_n;
	assign fall    = sel && !s_reg.held && s_reg.sck_d && !s_reg.sync.sck;
	assign rise    = sel && !s_reg.held && !s_reg.sck_d && s_reg.sync.sck;
	assign cs_rise = s_reg.sync.cs_n && !s_reg.cs_d;
	assign busy    = (s_reg.prog != eeprom_pkg::PG_IDLE);
	assign in_byte = {s_reg.sh_in[6:0], s_reg.sync.si};
	// upper nibble reads zero
	assign status  = {4'h0, s_reg.bp, s_reg.wel, busy};
	assign pop = pop_valid && (s_reg.prog == eeprom_pkg::PG_DRAIN);
	// output is released on a held frame at once, not at the next clock edge
	assign so_out = s_reg.so_q;
	assign so_oe  = sel && s_reg.reading && !s_reg.held && s_reg.sync.hold_n;

	always_comb
	begin
		s_next       = s_reg;
		push         = 1'b0;
		push_entry   = '0;
		flush        = 1'b0;
		s_next.meta  = '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n, wp_n: wp_n};
		s_next.sync  = s_reg.meta;
		s_next.sck_d = s_reg.sync.sck;
		s_next.cs_d  = s_reg.sync.cs_n;
		// hold takes or leaves effect only while the serial clock is high, and is dropped on deselection
		if (!sel)
			s_next.held = 1'b0;
		else if (s_reg.sync.sck)
			s_next.held = !s_reg.sync.hold_n;

		if (!sel)
		begin
			s_next.phase   = eeprom_pkg::PH_OPCODE;
			s_next.bitcnt  = 3'h0;
			s_next.reading = 1'b0;
		end
		else if (fall && !s_reg.reading)
		begin
			s_next.sh_in  = in_byte;
			s_next.bitcnt = 3'(s_reg.bitcnt + 3'h1);
			if (s_reg.bitcnt == 3'h7)
			begin
				case (s_reg.phase)
					eeprom_pkg::PH_OPCODE:
					begin
						s_next.cmd   = in_byte;
						s_next.phase = eeprom_pkg::PH_IGNORE;
						// while programming only the status read is honoured
						if (busy)
						begin
							if (in_byte == `OP_RD_STAT)
							begin
								s_next.out_sh  = status;
								s_next.reading = 1'b1;
								s_next.phase   = eeprom_pkg::PH_READ;
							end
						end
						else
						begin
							casez (in_byte)
								`OP_SET_WEL: s_next.wel = 1'b1;
								`OP_CLR_WEL: s_next.wel = 1'b0;
								`OP_RD_STAT:
								begin
									s_next.out_sh  = status;
									s_next.reading = 1'b1;
									s_next.phase   = eeprom_pkg::PH_READ;
								end
								`OP_WR_STAT: s_next.phase = eeprom_pkg::PH_DATA;
								`OP_RD_ARRAY, `OP_WR_ARRAY:
								begin
									s_next.addr[8] = in_byte[`INSTR_A8];
									s_next.phase   = eeprom_pkg::PH_ADDR;
								end
								default: s_next.phase = eeprom_pkg::PH_IGNORE;
							endcase
						end
					end
					eeprom_pkg::PH_ADDR:
					begin
						s_next.addr = {s_reg.cmd[`INSTR_A8], in_byte};
						if (s_reg.cmd[0])
						begin
							s_next.out_sh  = mem[{s_reg.cmd[`INSTR_A8], in_byte}];
							s_next.reading = 1'b1;
							s_next.phase   = eeprom_pkg::PH_READ;
						end
						else
							s_next.phase = eeprom_pkg::PH_DATA;
					end
					eeprom_pkg::PH_DATA:
					begin
						if (s_reg.cmd == `OP_WR_STAT)
						begin
							if (s_reg.sync.wp_n && s_reg.wel)
							begin
								s_next.bp_new  = in_byte[`ST_BP_HI:`ST_BP_LO];
								s_next.bp_pend = 1'b1;
							end
							s_next.phase = eeprom_pkg::PH_IGNORE;
						end
						else
						begin
							// a full staging buffer drops the byte rather than stall the master
							if (s_reg.sync.wp_n && s_reg.wel && !is_protected(s_reg.addr, s_reg.bp)
							    && push_ready)
							begin
								push       = 1'b1;
								push_entry = '{addr: s_reg.addr, data: in_byte};
							end
							// page writes wrap within a four-byte page
							s_next.addr = {s_reg.addr[8:2], 2'(s_reg.addr[1:0] + 2'h1)};
						end
					end
					default: s_next.phase = eeprom_pkg::PH_IGNORE;
				endcase
			end
		end
		else if (rise && s_reg.reading)
		begin
			s_next.so_q   = s_reg.out_sh[7];
			s_next.bitcnt = 3'(s_reg.bitcnt + 3'h1);
			if (s_reg.bitcnt == 3'h7)
			begin
				if (s_reg.cmd == `OP_RD_STAT)
					s_next.out_sh = status;
				else
				begin
					// sequential read rolls over at the end of the array
					s_next.addr   = 9'(s_reg.addr + 9'h001);
					s_next.out_sh = mem[9'(s_reg.addr + 9'h001)];
				end
			end
			else
				s_next.out_sh = {s_reg.out_sh[6:0], 1'b0};
		end

		case (s_reg.prog)
			eeprom_pkg::PG_IDLE:
			begin
				if (cs_rise && (pop_valid || s_reg.bp_pend))
				begin
					if (s_reg.sync.wp_n)
					begin
						s_next.prog = eeprom_pkg::PG_DRAIN;
						s_next.wel  = 1'b0;
					end
					else
					begin
						flush          = 1'b1;
						s_next.bp_pend = 1'b0;
					end
				end
			end
			eeprom_pkg::PG_DRAIN:
			begin
				// once begun, a guard fall no longer aborts the cycle
				if (s_reg.bp_pend)
				begin
					s_next.bp      = s_reg.bp_new;
					s_next.bp_pend = 1'b0;
				end
				if (!pop_valid && !s_reg.bp_pend)
				begin
					s_next.prog     = eeprom_pkg::PG_WAIT;
					s_next.wait_cnt = '0;
				end
			end
			eeprom_pkg::PG_WAIT:
			begin
				s_next.wait_cnt = `WAIT_W'(s_reg.wait_cnt + 1'b1);
				if (s_reg.wait_cnt == `WAIT_W'(WRITE_CYCLES - 1))
					s_next.prog = eeprom_pkg::PG_IDLE;
			end
			default: s_next.prog = eeprom_pkg::PG_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s_reg         <= '0;
			s_reg.meta    <= '{cs_n: 1'b1, sck: 1'b1, si: 1'b0, hold_n: 1'b1, wp_n: 1'b0};
			s_reg.sync    <= '{cs_n: 1'b1, sck: 1'b1, si: 1'b0, hold_n: 1'b1, wp_n: 1'b0};
			s_reg.sck_d   <= 1'b1;
			s_reg.cs_d    <= 1'b1;
			s_reg.phase   <= eeprom_pkg::PH_OPCODE;
			s_reg.prog    <= eeprom_pkg::PG_IDLE;
			s_reg.bp      <= `RST_BP;
			s_reg.wel     <= `RST_WEL;
		end
		else
			s_reg <= s_next;
	end

	// array content is non-volatile and therefore not reset
	always_ff @(posedge sys_clk)
	begin
		if (pop)
			mem[pop_entry.addr] <= pop_entry.data;
	end

	write_fifo #(
		.WIDTH     ($bits(eeprom_pkg::wr_entry_t)),
		.DEPTH     (FIFO_DEPTH)
	) u_write_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.flush     (flush),
		.in_valid  (push),
		.in_ready  (push_ready),
		.in_data   (push_entry),
		.out_valid (pop_valid),
		.out_ready (pop),
		.out_data  (pop_entry)
	);
endmodule : serial_eeprom_command_port

// ==== tb/eeprom_port_monitor.sv ====
/*
 * Port checker of the serial EEPROM command port.
 * Assumes pins stay steady for many sys_clk around each change.
 */
`timescale 1ns/1ps
module eeprom_port_monitor (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic hold_n,
	input wire logic so_out,
	input wire logic so_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	desel_off_a: assert property (cs_n [*4] |-> !so_oe)
		else $error("output driven while deselected");
	hold_off_a: assert property (!hold_n [*4] |-> !so_oe)
		else $error("output driven while suspended");
	rise_shift_a: assert property ((so_oe && !sck) [*6] |-> $stable(so_out))
		else $error("output changed in clock low time");
	oe_rise_a: assert property ($rose(so_oe) |-> !cs_n && hold_n)
		else $error("output enabled outside a transfer");
	oe_fall_a: assert property ($fell(so_oe) |-> cs_n || !hold_n)
		else $error("output released mid read");
	opcode_quiet_a: assert property ($fell(cs_n) |-> !so_oe [*8])
		else $error("output driven during opcode");
	frame_age_a: assert property (so_oe |-> !$past(cs_n, 8))
		else $error("output driven too soon after select");
	held_quiet_a: assert property (!hold_n ##1 !hold_n |=> !so_oe || hold_n)
		else $error("output driven during hold");
	cover property ($rose(so_oe));
	cover property (!hold_n && !cs_n);
	cover property ($rose(cs_n));
endmodule : eeprom_port_monitor

// ==== tb/spi_master_model.sv ====
/*
 * Serial master model, mode 2, 125 ns serial clock while framed.
 * Assumes the bench resolves the serial output wire.
 */
`timescale 1ns/1ps
module spi_master_model (
	input  wire logic sys_clk,
	input  wire logic so,
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	output logic      hold_n
);
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b1;
		si = 1'b0;
		hold_n = 1'b1;
	end
	task automatic gap(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : gap
	// bytes come from the top of tx; rx keeps the last byte seen
	task automatic frame(input int n, input logic [31:0] tx, input logic pause,
		output logic [7:0] rx);
		cs_n <= 1'b0;
		gap(8);
		for (int k = 0; k < n; k++)
			for (int i = 7; i >= 0; i--)
			begin
				si <= tx[24 - 8 * k + i];
				if (pause && k == n - 1 && i == 4)
				begin
					// hold moves only while the clock is high
					gap(6);
					hold_n <= 1'b0;
					// a clock pulse while suspended must not shift anything
					gap(12);
					sck <= 1'b0;
					gap(13);
					sck <= 1'b1;
					gap(15);
					hold_n <= 1'b1;
				end
				gap(12);
				rx[i] = so;
				sck <= 1'b0;
				gap(13);
				sck <= 1'b1;
			end
		gap(8);
		cs_n <= 1'b1;
		gap(12);
	endtask : frame
endmodule : spi_master_model

// ==== tb/serial_eeprom_command_port_tb.sv ====
/*
 * Testbench of the serial EEPROM command port with a master model.
 * Assumes a short program cycle set through WRITE_CYCLES.
 */
`timescale 1ns/1ps
`include "eeprom_regs.svh"
module serial_eeprom_command_port_tb;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        wp_n = 1'b1;
	logic        so_last = 1'b0;
	logic        cs_n;
	logic        sck;
	logic        si;
	logic        hold_n;
	logic        so_out;
	logic        so_oe;
	logic [15:0] seed = 16'hD174;
	logic [7:0]  rx;
	logic [7:0]  d1;
	logic [7:0]  d3;
	logic [8:0]  a;
	int          error_cnt = 0;
	int          num_checks = 0;
	// a released line shows the inverse of its last value
	wire         so_w = so_oe ? so_out : ~so_last;

	serial_eeprom_command_port #(.WRITE_CYCLES(2000), .FIFO_DEPTH(8))
		serial_eeprom_command_port_inst (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n),
		.sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe));
	spi_master_model spi_master_model_inst (.sys_clk(sys_clk), .so(so_w), .cs_n(cs_n),
		.sck(sck), .si(si), .hold_n(hold_n));

	initial forever #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (so_oe) so_last <= so_out;

	function automatic logic [15:0] xs(input logic [15:0] s);
		logic [15:0] t;
		t = s ^ (s << 7);
		t = t ^ (t >> 9);
		return t ^ (t << 8);
	endfunction : xs
	function automatic logic [7:0] stat(input logic [1:0] bp, input logic wel, input logic bsy);
		return {4'h0, bp, wel, bsy};
	endfunction : stat
	task automatic conclude;
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cmd(input int n, input logic [31:0] tx);
		spi_master_model_inst.frame(n, tx, 1'b0, rx);
	endtask : cmd
	// upper nibble reads zero, and only the low one is compared
	task automatic sf(input logic [7:0] exp);
		cmd(2, {`OP_RD_STAT, 24'h0});
		chk("status", exp, {4'h0, rx[3:0]});
	endtask : sf
	task automatic wait_ready;
		rx = 8'h01;
		for (int i = 0; i < 20 && rx[0] !== 1'b0; i++)
			cmd(2, {`OP_RD_STAT, 24'h0});
		chk("ready", 8'h00, {7'h0, rx[0]});
		if (rx[0] !== 1'b0)
			conclude();
	endtask : wait_ready

	initial
	begin
		seed = xs(seed);
		d1 = seed[7:0];
		seed = xs(seed);
		d3 = seed[7:0];
		seed = xs(seed);
		a = seed[8:0] % 9'h180;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		sf(stat(2'h0, 1'b0, 1'b0));
		cmd(1, {`OP_SET_WEL, 24'h0});
		sf(stat(2'h0, 1'b1, 1'b0));
		cmd(1, {`OP_CLR_WEL, 24'h0});
		sf(stat(2'h0, 1'b0, 1'b0));
		wp_n <= 1'b0;
		cmd(1, {`OP_SET_WEL, 24'h0});
		cmd(2, {`OP_WR_STAT, 8'h0C, 16'h0});
		sf(stat(2'h0, 1'b1, 1'b0));
		wp_n <= 1'b1;
		cmd(3, {8'h0A, 8'hA5, d1, 8'h0});
		sf(stat(2'h0, 1'b0, 1'b1));
		// write enable is refused while the program cycle runs
		cmd(1, {`OP_SET_WEL, 24'h0});
		wait_ready();
		sf(stat(2'h0, 1'b0, 1'b0));
		cmd(1, {`OP_SET_WEL, 24'h0});
		cmd(2, {`OP_WR_STAT, 8'h04, 16'h0});
		wait_ready();
		sf(stat(2'h1, 1'b0, 1'b0));
		cmd(1, {`OP_SET_WEL, 24'h0});
		cmd(3, {8'h0A, 8'hA5, ~d1, 8'h0});
		sf(stat(2'h1, 1'b1, 1'b0));
		// guard falls after the data byte is taken but before deselection
		fork
			cmd(3, {4'h0, a[8], 3'b010, a[7:0], ~d3, 8'h0});
			begin
				repeat (605) @(posedge sys_clk);
				wp_n <= 1'b0;
			end
		join
		sf(stat(2'h1, 1'b1, 1'b0));
		wp_n <= 1'b1;
		cmd(3, {4'h0, a[8], 3'b010, a[7:0], d3, 8'h0});
		wait_ready();
		cmd(3, {8'h0B, 8'hA5, 16'h0});
		chk("data", d1, rx);
		spi_master_model_inst.frame(3, {4'h0, a[8], 3'b011, a[7:0], 16'h0}, 1'b1, rx);
		chk("data", d3, rx);
		conclude();
	end
endmodule : serial_eeprom_command_port_tb

bind serial_eeprom_command_port eeprom_port_monitor eeprom_port_monitor_inst (
	.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .hold_n(hold_n),
	.so_out(so_out), .so_oe(so_oe));
